/* File: pio_params.svh */
// constants of the parallel expansion port
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH

// processor-side widths
`define PIO_CPU_DATA_W 32
`define PIO_CPU_ADDR_W 13

// connector-side widths
`define PIO_PORT_DATA_W 16
`define PIO_PORT_ADDR_W 4

// program address taken by the processor after reset
`define PIO_RESET_VECTOR 24'h000000
`define PIO_VECTOR_W 24

// reset values of the connector pins
`define PIO_STROBE_IDLE 1'h1
`define PIO_RW_IDLE 1'h1
`define PIO_ACK_IDLE 1'h1

`endif

/* File: pio_pkg.sv */
// types shared by the parallel expansion port modules
package pio_pkg;

  // processor-side access sequencing
  typedef enum logic [1:0] {
    PIO_CPU_IDLE,
    PIO_CPU_WAIT,
    PIO_CPU_DONE
  } pio_cpu_state_t;

  // connector-side strobe sequencing
  typedef enum logic [1:0] {
    PIO_LINK_IDLE,
    PIO_LINK_STROBE,
    PIO_LINK_HOLD
  } pio_link_state_t;

endpackage : pio_pkg

/* File: pio_xfer_if.sv */
// crossing bundle between processor-side and connector-side logic
`timescale 1ns/1ns
`default_nettype none
`include "pio_params.svh"

interface pio_xfer_if;
  // written in the processor domain, held stable while a request is open
  logic reqToggle;
  logic rw;
  logic [`PIO_PORT_ADDR_W-1:0] addr;
  logic [`PIO_PORT_DATA_W-1:0] wdata;
  // written in the link domain, stable once ackToggle has moved
  logic ackToggle;
  logic [`PIO_PORT_DATA_W-1:0] rdata;

  modport cpu (output reqToggle, output rw, output addr, output wdata,
               input ackToggle, input rdata);
  modport link (input reqToggle, input rw, input addr, input wdata,
                output ackToggle, output rdata);
endinterface : pio_xfer_if

`default_nettype wire

/* File: pio_link_side.sv */
// connector-side strobe engine, runs on the link clock
`timescale 1ns/1ns
`default_nettype none
`include "pio_params.svh"

module pio_link_side
  import pio_pkg::*;
(
  input wire logic linkClk,
  input wire logic reset,
  pio_xfer_if.link xfer,
  input wire logic readyPin_n,
  input wire logic [`PIO_PORT_DATA_W-1:0] dataPinIn,
  output logic ioStrobe_n,
  output logic readWrite,
  output logic [`PIO_PORT_ADDR_W-1:0] portAddr,
  output logic [`PIO_PORT_DATA_W-1:0] dataPinOut,
  output logic dataPinOe
);

  logic [1:0] resetSync;
  logic linkReset;
  logic [1:0] reqSync;
  logic reqSeen;
  logic [1:0] readySync;
  logic [`PIO_PORT_DATA_W-1:0] dataSync0;
  logic [`PIO_PORT_DATA_W-1:0] dataSync1;
  logic ackToggle;
  logic [`PIO_PORT_DATA_W-1:0] rdata;
  pio_link_state_t state;
  pio_link_state_t next_state;

  wire newRequest = reqSync[1] ^ reqSeen;
  wire cardReady = ~readySync[1];

  assign linkReset = resetSync[1];
  assign xfer.ackToggle = ackToggle;
  assign xfer.rdata = rdata;

  // reset and pins enter this domain through two flops each
  always_ff @(posedge linkClk) begin
    resetSync <= {resetSync[0], reset};
    reqSync <= {reqSync[0], xfer.reqToggle};
    readySync <= {readySync[0], readyPin_n};
    dataSync0 <= dataPinIn;
    dataSync1 <= dataSync0;
  end

  // strobe held until the card answers ready, however long that takes
  always_comb begin
    next_state = state;
    unique case (state)
      PIO_LINK_IDLE: if (newRequest) next_state = PIO_LINK_STROBE;
      PIO_LINK_STROBE: if (cardReady) next_state = PIO_LINK_HOLD;
      PIO_LINK_HOLD: if (!cardReady) next_state = PIO_LINK_IDLE;
    endcase
  end

  always_ff @(posedge linkClk) begin
    if (linkReset) begin
      state <= PIO_LINK_IDLE;
      reqSeen <= 1'h0;
      ackToggle <= 1'h0;
      rdata <= '0;
      ioStrobe_n <= `PIO_STROBE_IDLE;
      readWrite <= `PIO_RW_IDLE;
      portAddr <= '0;
      dataPinOut <= '0;
      dataPinOe <= 1'h0;
    end else begin
      state <= next_state;
      if (state == PIO_LINK_IDLE && newRequest) begin
        reqSeen <= reqSync[1];
        ioStrobe_n <= 1'h0;
        readWrite <= xfer.rw;
        portAddr <= xfer.addr;
        dataPinOut <= xfer.wdata;
        dataPinOe <= ~xfer.rw;
      end
      if (state == PIO_LINK_STROBE && cardReady) begin
        rdata <= dataSync1;
        ackToggle <= ~ackToggle;
        ioStrobe_n <= 1'h1;
        dataPinOe <= 1'h0;
      end
    end
  end

endmodule : pio_link_side

`default_nettype wire

/* File: pio_expansion_port.sv */
// parallel expansion port between the processor and an external card
`timescale 1ns/1ns
`default_nettype none
`include "pio_params.svh"

module pio_expansion_port
  import pio_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic linkClk,
  // processor expansion bus
  input wire logic cpuStrobe_n,
  input wire logic cpuReadWrite,
  input wire logic [`PIO_CPU_ADDR_W-1:0] cpuAddr,
  input wire logic [`PIO_CPU_DATA_W-1:0] cpuWriteData,
  output logic [`PIO_CPU_DATA_W-1:0] cpuReadData,
  output logic cpuReady_n,
  input wire logic cpuIrqAck,
  input wire logic cpuFlagZero,
  // processor control
  output logic cpuReset,
  output logic [`PIO_VECTOR_W-1:0] cpuResetVector,
  output logic host_irq,
  output logic cpuIrqOne_n,
  // host control port bits
  input wire logic hostResetReq,
  input wire logic hostIrqReq,
  // card connector
  output logic io_strobe_n,
  output logic readWrite,
  output logic [`PIO_PORT_ADDR_W-1:0] portAddr,
  input wire logic [`PIO_PORT_DATA_W-1:0] portDataIn,
  output logic [`PIO_PORT_DATA_W-1:0] portDataOut,
  output logic portDataOe,
  input wire logic portReady_n,
  input wire logic card_irq_n,
  output logic irq_ack_n,
  output logic processor_flag_zero,
  output logic ioReset_n,
  output logic phase_one_clock,
  output logic phase_three_clock,
  output logic bufferedClock
);

  pio_xfer_if xfer();

  // only the low four address bits of the bus reach the card
  function automatic logic [`PIO_PORT_ADDR_W-1:0] cardAddr(
    input logic [`PIO_CPU_ADDR_W-1:0] a);
    cardAddr = a[`PIO_PORT_ADDR_W-1:0];
  endfunction : cardAddr

  // synchronisers for pins that come from outside this domain
  logic [1:0] hostResetSync;
  logic [1:0] hostIrqSync;
  logic [1:0] cardIrqSync;
  logic [1:0] ackSync;
  logic ackSeen;

  always_ff @(posedge clk) begin
    hostResetSync <= {hostResetSync[0], hostResetReq};
    hostIrqSync <= {hostIrqSync[0], hostIrqReq};
    cardIrqSync <= {cardIrqSync[0], card_irq_n};
    ackSync <= {ackSync[0], xfer.ackToggle};
  end

  wire hostReset = hostResetSync[1];
  wire hostIrq = hostIrqSync[1];
  wire cardIrq_n = cardIrqSync[1];
  wire ackArrived = ackSync[1] ^ ackSeen;

  // processor-side sequencing of one strobed access
  pio_cpu_state_t state;
  pio_cpu_state_t next_state;
  logic reqToggle;
  logic reqRw;
  logic [`PIO_PORT_ADDR_W-1:0] reqAddr;
  logic [`PIO_PORT_DATA_W-1:0] reqData;

  wire accessStart = (state == PIO_CPU_IDLE) && !cpuStrobe_n;
  wire accessOpen = !cpuStrobe_n;

  always_comb begin
    next_state = state;
    unique case (state)
      PIO_CPU_IDLE: if (accessStart) next_state = PIO_CPU_WAIT;
      PIO_CPU_WAIT: if (ackArrived) next_state = PIO_CPU_DONE;
      PIO_CPU_DONE: if (!accessOpen) next_state = PIO_CPU_IDLE;
    endcase
  end

  assign xfer.reqToggle = reqToggle;
  assign xfer.rw = reqRw;
  assign xfer.addr = reqAddr;
  assign xfer.wdata = reqData;

  // wait states: ready stays high until the card has answered
  assign cpuReady_n = !(state == PIO_CPU_DONE);

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= PIO_CPU_IDLE;
      ackSeen <= 1'h0;
      reqToggle <= 1'h0;
      reqRw <= `PIO_RW_IDLE;
      reqAddr <= '0;
      reqData <= '0;
    end else begin
      state <= next_state;
      if (accessStart) begin
        // request fields settle together with the toggle; the far side
        // reads them only after two flops, so they are stable by then
        reqToggle <= ~reqToggle;
        reqRw <= cpuReadWrite;
        reqAddr <= cardAddr(cpuAddr);
        reqData <= cpuWriteData[`PIO_PORT_DATA_W-1:0];
      end
      if (state == PIO_CPU_WAIT && ackArrived) begin
        ackSeen <= ackSync[1];
      end
    end
  end

  // read data: upper half reads zero since those lines are not wired
  always_ff @(posedge clk) begin
    if (reset) begin
      cpuReadData <= '0;
    end else if (state == PIO_CPU_WAIT && ackArrived) begin
      cpuReadData <= {{(`PIO_CPU_DATA_W-`PIO_PORT_DATA_W){1'h0}}, xfer.rdata};
    end
  end

  // processor reset, vector and host interrupt
  always_ff @(posedge clk) begin
    if (reset) begin
      cpuReset <= 1'h1;
      cpuResetVector <= `PIO_RESET_VECTOR;
      host_irq <= 1'h0;
      ioReset_n <= 1'h0;
    end else begin
      cpuReset <= hostReset;
      cpuResetVector <= `PIO_RESET_VECTOR;
      host_irq <= hostIrq;
      ioReset_n <= 1'h1;
    end
  end

  // card interrupt in, acknowledge and flag out
  always_ff @(posedge clk) begin
    if (reset) begin
      cpuIrqOne_n <= 1'h1;
      irq_ack_n <= `PIO_ACK_IDLE;
      processor_flag_zero <= 1'h0;
    end else begin
      cpuIrqOne_n <= cardIrq_n;
      irq_ack_n <= ~cpuIrqAck;
      processor_flag_zero <= cpuFlagZero;
    end
  end

  // phase clocks: half the link clock, in opposite phase, plus a copy
  logic [1:0] linkResetSync;
  logic phaseOne;

  always_ff @(posedge linkClk) begin
    linkResetSync <= {linkResetSync[0], reset};
  end

  always_ff @(posedge linkClk) begin
    if (linkResetSync[1]) begin
      phaseOne <= 1'h0;
      phase_one_clock <= 1'h0;
      phase_three_clock <= 1'h1;
      bufferedClock <= 1'h0;
    end else begin
      phaseOne <= ~phaseOne;
      phase_one_clock <= phaseOne;
      phase_three_clock <= ~phaseOne;
      bufferedClock <= phaseOne;
    end
  end

  // connector-side strobe engine
  pio_link_side pio_link_side_i (
    .linkClk(linkClk),
    .reset(reset),
    .xfer(xfer.link),
    .readyPin_n(portReady_n),
    .dataPinIn(portDataIn),
    .ioStrobe_n(io_strobe_n),
    .readWrite(readWrite),
    .portAddr(portAddr),
    .dataPinOut(portDataOut),
    .dataPinOe(portDataOe)
  );

endmodule : pio_expansion_port

`default_nettype wire

/* File: pio_card_model.sv */
// behavioural data acquisition card on the connector side
`timescale 1ns/1ns
`default_nettype none

module pio_card_model
  import pio_pkg::*;
(
  input wire logic linkClk,
  input wire logic io_strobe_n,
  input wire logic readWrite,
  input wire logic [3:0] portAddr,
  input wire logic [15:0] portDataOut,
  input wire logic [3:0] waitCycles,
  output logic portReady_n,
  output logic [15:0] portDataIn
);
  logic [15:0] mem [16];
  logic [3:0] cnt;

  initial begin
    portReady_n = 1'h1;
    portDataIn = 16'h0000;
    cnt = 4'h0;
  end

  // released bus toggles so a stale capture cannot pass by luck
  always @(posedge linkClk) begin
    if (io_strobe_n) begin
      cnt <= 4'h0;
      portReady_n <= 1'h1;
      portDataIn <= ~portDataIn;
    end else if (cnt != waitCycles) begin
      cnt <= cnt + 4'h1;
    end else begin
      portReady_n <= 1'h0;
      // only four address lines reach the card, so it aliases every 16
      if (readWrite) portDataIn <= mem[portAddr];
      else mem[portAddr] <= portDataOut;
    end
  end
endmodule : pio_card_model

`default_nettype wire

/* File: pio_expansion_port_properties.sv */
// timing properties of the expansion port top module
`timescale 1ns/1ns
`default_nettype none
`include "pio_params.svh"

module pio_expansion_port_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic linkClk,
  input wire logic cpuStrobe_n,
  input wire logic [`PIO_CPU_DATA_W-1:0] cpuReadData,
  input wire logic cpuReady_n,
  input wire logic cpuFlagZero,
  input wire logic processor_flag_zero,
  input wire logic hostIrqReq,
  input wire logic host_irq,
  input wire logic hostResetReq,
  input wire logic cpuReset,
  input wire logic card_irq_n,
  input wire logic cpuIrqOne_n,
  input wire logic io_strobe_n,
  input wire logic readWrite,
  input wire logic portDataOe,
  input wire logic portReady_n,
  input wire logic phase_one_clock,
  input wire logic phase_three_clock
);
  // link-side outputs leave reset a few link edges after reset falls
  logic [2:0] linkRstHold = 3'h7;
  always_ff @(posedge linkClk) begin
    linkRstHold <= {linkRstHold[1:0], reset};
  end
  property p_rd_hi;
    @(posedge clk) disable iff (reset) !cpuReady_n |-> cpuReadData[31:16] == 16'h0000;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read half not zero");
  property p_ready;
    @(posedge clk) disable iff (reset) !cpuReady_n && !cpuStrobe_n |=> !cpuReady_n;
  endproperty
  a_ready: assert property (p_ready) else $error("ready dropped under strobe");
  property p_flag;
    @(posedge clk) disable iff (reset)
      !$past(reset) |-> processor_flag_zero == $past(cpuFlagZero);
  endproperty
  a_flag: assert property (p_flag) else $error("flag copy wrong");
  property p_hirq;
    @(posedge clk) disable iff (reset) $rose(hostIrqReq) |-> ##[1:4] host_irq;
  endproperty
  a_hirq: assert property (p_hirq) else $error("host irq not passed");
  property p_hrst;
    @(posedge clk) disable iff (reset) $rose(hostResetReq) |-> ##[1:4] cpuReset;
  endproperty
  a_hrst: assert property (p_hrst) else $error("host reset not passed");
  property p_cirq;
    @(posedge clk) disable iff (reset) $fell(card_irq_n) |-> ##[1:4] !cpuIrqOne_n;
  endproperty
  a_cirq: assert property (p_cirq) else $error("card irq not passed");
  property p_oe;
    @(posedge linkClk) disable iff (reset || linkRstHold != 3'h0)
      portDataOe |-> !io_strobe_n && !readWrite;
  endproperty
  a_oe: assert property (p_oe) else $error("data driven outside write");
  property p_end;
    @(posedge linkClk) disable iff (reset || linkRstHold != 3'h0)
      $fell(portReady_n) |-> ##[1:4] io_strobe_n;
  endproperty
  a_end: assert property (p_end) else $error("strobe not ended by ready");
  property p_phase;
    @(posedge linkClk) disable iff (reset || linkRstHold != 3'h0)
      phase_three_clock != phase_one_clock;
  endproperty
  a_phase: assert property (p_phase) else $error("phase clocks not opposite");
  c_write: cover property (@(posedge linkClk) portDataOe);
  c_read: cover property (@(posedge linkClk) !io_strobe_n && readWrite);
  c_irq: cover property (@(posedge clk) !cpuIrqOne_n);
endmodule : pio_expansion_port_properties

bind pio_expansion_port pio_expansion_port_properties pio_expansion_port_properties_i (
  .clk, .reset, .linkClk, .cpuStrobe_n, .cpuReadData, .cpuReady_n, .cpuFlagZero,
  .processor_flag_zero, .hostIrqReq, .host_irq, .hostResetReq, .cpuReset, .card_irq_n,
  .cpuIrqOne_n, .io_strobe_n, .readWrite, .portDataOe, .portReady_n, .phase_one_clock,
  .phase_three_clock);

`default_nettype wire

/* File: pio_expansion_port_tb_top.sv */
// self-checking bench for the parallel expansion port
`timescale 1ns/1ns
`default_nettype none

module pio_expansion_port_tb_top;
  logic clk, reset, linkClk, cpuStrobe_n, cpuReadWrite, cpuReady_n, cpuIrqAck, cpuFlagZero;
  logic cpuReset, host_irq, cpuIrqOne_n, hostResetReq, hostIrqReq, io_strobe_n, readWrite;
  logic portDataOe, portReady_n, card_irq_n, irq_ack_n, processor_flag_zero, ioReset_n;
  logic phase_one_clock, phase_three_clock, bufferedClock;
  logic [12:0] cpuAddr;
  logic [31:0] cpuWriteData, cpuReadData;
  logic [23:0] cpuResetVector;
  logic [3:0] portAddr, cardWait;
  logic [15:0] portDataIn, portDataOut;
  int fails = 0;
  int cmp_count = 0;

  pio_expansion_port pio_expansion_port_i (.clk, .reset, .linkClk, .cpuStrobe_n,
    .cpuReadWrite, .cpuAddr, .cpuWriteData, .cpuReadData, .cpuReady_n, .cpuIrqAck,
    .cpuFlagZero, .cpuReset, .cpuResetVector, .host_irq, .cpuIrqOne_n, .hostResetReq,
    .hostIrqReq, .io_strobe_n, .readWrite, .portAddr, .portDataIn, .portDataOut,
    .portDataOe, .portReady_n, .card_irq_n, .irq_ack_n, .processor_flag_zero, .ioReset_n,
    .phase_one_clock, .phase_three_clock, .bufferedClock);
  pio_card_model pio_card_model_i (.linkClk, .io_strobe_n, .readWrite, .portAddr,
    .portDataOut, .waitCycles(cardWait), .portReady_n, .portDataIn);

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    linkClk = 1'h0;
    #13;
    forever #40 linkClk = ~linkClk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task end_sim;
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  // one strobed access, held until the processor sees ready
  task automatic xfer(input logic rw, input logic [12:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    int n;
    n = 0;
    cpuReadWrite <= rw;
    cpuAddr <= a;
    cpuWriteData <= wd;
    cpuStrobe_n <= 1'h0;
    do begin
      @(posedge clk);
      n++;
    end while (cpuReady_n !== 1'h0 && n < 300);
    if (n >= 300) fails++;
    rd = cpuReadData;
    cpuStrobe_n <= 1'h1;
    repeat (2) @(posedge clk);
  endtask : xfer

  task t_bus;
    logic [31:0] rd;
    cardWait <= 4'h0;
    xfer(1'h0, 13'h0005, 32'hABCD1234, rd);
    cardWait <= 4'h5;
    xfer(1'h0, 13'h1FFA, 32'h5555A5C3, rd);
    xfer(1'h1, 13'h0035, 32'h00000000, rd);
    chk(rd, 32'h00001234);
    xfer(1'h1, 13'h000A, 32'h00000000, rd);
    chk(rd, 32'h0000A5C3);
    $display("bus test done");
  endtask : t_bus

  task t_ctrl;
    hostResetReq <= 1'h1;
    hostIrqReq <= 1'h1;
    repeat (5) @(posedge clk);
    chk(cpuReset, 1'h1);
    chk(host_irq, 1'h1);
    chk({8'h00, cpuResetVector}, 32'h00000000);
    hostResetReq <= 1'h0;
    hostIrqReq <= 1'h0;
    repeat (5) @(posedge clk);
    chk({cpuReset, host_irq}, 2'h0);
    $display("control test done");
  endtask : t_ctrl

  task t_card;
    card_irq_n <= 1'h0;
    cpuIrqAck <= 1'h1;
    cpuFlagZero <= 1'h1;
    repeat (5) @(posedge clk);
    chk({cpuIrqOne_n, irq_ack_n, processor_flag_zero}, 3'h1);
    card_irq_n <= 1'h1;
    cpuIrqAck <= 1'h0;
    cpuFlagZero <= 1'h0;
    repeat (5) @(posedge clk);
    chk({cpuIrqOne_n, irq_ack_n, processor_flag_zero, ioReset_n}, 4'hD);
    $display("card test done");
  endtask : t_card

  // clk edges never meet link edges, so each 80 ns step spans one rising link edge
  task t_clk;
    logic prev;
    repeat (4) begin
      prev = phase_one_clock;
      repeat (2) @(posedge clk);
      chk(phase_one_clock, !prev);
      chk({phase_three_clock, bufferedClock}, {~phase_one_clock, phase_one_clock});
    end
    $display("clock test done");
  endtask : t_clk

  initial begin
    reset = 1'h1;
    {cpuStrobe_n, cpuReadWrite, card_irq_n} = 3'h7;
    {cpuIrqAck, cpuFlagZero, hostResetReq, hostIrqReq} = 4'h0;
    cpuAddr = 13'h0000;
    cpuWriteData = 32'h00000000;
    cardWait = 4'h0;
    repeat (5) @(posedge clk);
    chk({ioReset_n, cpuReset}, 2'h1);
    reset <= 1'h0;
    // the link side leaves reset a few of its own edges later
    repeat (10) @(posedge clk);
    chk({io_strobe_n, readWrite, portDataOe}, 3'h6);
    t_bus();
    t_ctrl();
    t_card();
    t_clk();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_sim();
  end
endmodule : pio_expansion_port_tb_top

`default_nettype wire
